//--- tb/fpc_ctrl_props.sv
// concurrent checks on the flash controller ports
`timescale 1ns/1ps
`include "fpc_regs.vh"
module fpc_ctrl_props #(
    parameter ADDR_W = 13
) (
    input wire       aclk,
    input wire       aresetn,
    input wire       s_axi_arvalid,
    input wire       s_axi_arready,
    input wire       s_axi_rvalid,
    input wire       s_axi_rready,
    input wire       s_axi_bvalid,
    input wire       s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire       dbg_prog_req,
    input wire       cpu_prog_req,
    input wire       prog_done,
    input wire       prog_refused,
    input wire       cpu_idle,
    input wire [7:0] trim_data_reg
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire req = dbg_prog_req || cpu_prog_req;

    AST_DONE_NOT_REFUSED: assert property (
        !(prog_done && prog_refused)) else $error("done and refused together");
    AST_DONE_CPU_HELD: assert property (
        prog_done |-> $past(cpu_idle) && $past(cpu_idle, 7))
        else $error("byte written without cpu held idle");
    AST_DONE_NEEDS_REQ: assert property (
        prog_done |-> $past(req)) else $error("done without request");
    AST_REFUSE_NEEDS_REQ: assert property (
        prog_refused |-> $past(req)) else $error("refusal without request");
    AST_DONE_IS_PULSE: assert property (
        prog_done |=> !prog_done) else $error("done longer than a cycle");
    AST_TRIM_CLEAR: assert property (
        $rose(aresetn) |-> trim_data_reg == 8'h00)
        else $error("trim not cleared by reset");
    AST_TRIM_BY_WRITE: assert property (
        $changed(trim_data_reg) |-> ##[0:2] s_axi_bvalid)
        else $error("trim changed without a bus write");
    AST_READ_ANSWER: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    AST_WRITE_ANSWER_ONCE: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answered twice");
    cover property (prog_done);
    cover property (prog_refused);
    cover property (s_axi_bvalid && s_axi_bresp == `FPC_RESP_SLVERR);
endmodule // fpc_ctrl_props

bind fpc_ctrl fpc_ctrl_props #(.ADDR_W(ADDR_W)) i_fpc_ctrl_props (
    .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .dbg_prog_req, .cpu_prog_req, .prog_done, .prog_refused, .cpu_idle,
    .trim_data_reg);

//--- tb/fpc_host_model.sv
// requester model: cpu load or debugger write of one flash byte
`timescale 1ns/1ps
module fpc_host_model (
    input  wire         aclk,
    input  wire         prog_done,
    input  wire         prog_refused,
    output logic        dbg_prog_req,
    output logic        cpu_prog_req,
    output logic [12:0] prog_addr,
    output logic [7:0]  prog_data
);
    initial begin
        dbg_prog_req = 1'b0;
        cpu_prog_req = 1'b0;
        prog_addr = 13'h0000;
        prog_data = 8'h00;
    end
    // request held until the controller answers, then dropped
    task automatic prog(input bit dbg, input logic [12:0] a,
                        input logic [7:0] d, output bit ok);
        @(posedge aclk);
        prog_addr <= a;
        prog_data <= d;
        dbg_prog_req <= dbg;
        cpu_prog_req <= !dbg;
        do @(posedge aclk); while (!(prog_done || prog_refused));
        ok = prog_done;
        dbg_prog_req <= 1'b0;
        cpu_prog_req <= 1'b0;
        prog_addr <= ~a;
        prog_data <= ~d;
    endtask
endmodule // fpc_host_model

//--- tb/tb.sv
// self-checking bench for the flash protect and program controller
`timescale 1ns/1ps
`include "fpc_regs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
    logic        aclk, aresetn;
    logic [13:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [12:0] mem_raddr;
    wire  [12:0] prog_addr;
    wire  [7:0]  prog_data, mem_rdata, trim_data_reg;
    wire         s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid;
    wire         s_axi_rvalid, prog_done, prog_refused, cpu_idle;
    wire  [1:0]  s_axi_bresp, s_axi_rresp, clock_source_select;
    wire  [31:0] s_axi_rdata;
    wire         dbg_prog_req, cpu_prog_req, wdog_reset_select;
    wire         wdog_always_on, brownout_always_on;
    wire         read_protect_opt, write_protect_opt;
    int          n_mismatch = 0, compares = 0, cyc = 0;
    logic [1:0]  rsp;
    logic [7:0]  rd;
    bit          ok;
    // rows: write flag, offset, data or expected byte, response
    localparam logic [31:0] TBL [11] = '{
        32'h0ff70000, 32'h1ff7a500, 32'h0ff7a500, 32'h00040002,
        32'h10040002, 32'h1ff80000, 32'h1ff85e00, 32'h0ff90000,
        32'h1ff80000, 32'h1ff90300, 32'h0ff90300};

    fpc_ctrl #(.ADDR_W(13)) i_fpc_ctrl (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .dbg_prog_req, .cpu_prog_req, .prog_addr, .prog_data, .prog_done,
        .prog_refused, .cpu_idle, .mem_raddr, .mem_rdata,
        .wdog_reset_select, .wdog_always_on, .clock_source_select,
        .brownout_always_on, .read_protect_opt, .write_protect_opt,
        .trim_data_reg);
    fpc_host_model i_fpc_host_model (.aclk, .prog_done, .prog_refused,
        .dbg_prog_req, .cpu_prog_req, .prog_addr, .prog_data);

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            stop_test;
        end
    end

    task stop_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task axw(input [11:0] a, input [7:0] d);
        s_axi_awaddr <= {a, 2'b00}; // register index to byte address
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
    endtask
    task axr(input [11:0] a);
        s_axi_araddr <= {a, 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rsp = s_axi_rresp;
        rd = s_axi_rdata[7:0];
    endtask
    task rdm(input [12:0] a);
        mem_raddr <= a;
        repeat (2) @(posedge aclk);
        rd = mem_rdata;
    endtask
    task pr(input bit dbg, input [12:0] a, input [7:0] d, input bit e);
        i_fpc_host_model.prog(dbg, a, d, ok);
        `CHK("program accepted", e, ok)
    endtask
    task unlock(input [7:0] cmd);
        axw(`FPC_OFF_CTRL, `FPC_CMD_UNLOCK1);
        axw(`FPC_OFF_CTRL, `FPC_CMD_UNLOCK2);
        axw(`FPC_OFF_CTRL, cmd);
        repeat (2) @(posedge aclk);
    endtask
    task opt(input [7:0] e);
        `CHK("options", e, {wdog_reset_select, wdog_always_on,
            clock_source_select, brownout_always_on, read_protect_opt,
            e[1], write_protect_opt})
    endtask

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, mem_raddr} = 73'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (TBL[k]) begin
            if (TBL[k][28]) axw(TBL[k][27:16], TBL[k][15:8]);
            else axr(TBL[k][27:16]);
            `CHK("response", TBL[k][1:0], rsp)
            if (!TBL[k][28] && TBL[k][1:0] == 2'b00)
                `CHK("read data", TBL[k][15:8], rd)
        end
        `CHK("trim port", 8'ha5, trim_data_reg)
        pr(1'b0, 13'h0600, 8'h00, 1'b0);
        unlock(`FPC_CMD_MASS);
        `CHK("erase busy", 1'b1, cpu_idle)
        while (cpu_idle) @(posedge aclk);
        opt(8'hff);
        rdm(13'h1234);
        `CHK("erased", `FPC_ERASED, rd)
        pr(1'b1, `FPC_OPT_ADDR, 8'h3e, 1'b1);
        pr(1'b0, 13'h1fff, 8'h0f, 1'b1);
        pr(1'b1, 13'h1fff, 8'hf3, 1'b1); // second and last pass
        rdm(13'h1fff);
        `CHK("cleared bits", 8'h03, rd)
        opt(8'h3e);
        axw(`FPC_OFF_CTRL, `FPC_CMD_PROT);
        pr(1'b0, 13'h1ff0, 8'h00, 1'b0);
        axw(`FPC_OFF_PROT, 8'h80);
        axw(`FPC_OFF_PROT, 8'h00);
        axr(`FPC_OFF_PROT);
        `CHK("protect", 8'h80, rd)
        axw(`FPC_OFF_CTRL, `FPC_CMD_RESET);
        axw(`FPC_OFF_PROT, 8'h03);
        unlock(`FPC_CMD_PAGE);
        while (cpu_idle) @(posedge aclk);
        rdm(13'h0650);
        `CHK("page erased", `FPC_ERASED, rd)
        rdm(13'h1fff);
        `CHK("outside page", 8'h03, rd)
        pr(1'b0, 13'h0700, 8'h12, 1'b1);
        pr(1'b1, 13'h0800, 8'h00, 1'b0);
        axw(`FPC_OFF_CTRL, `FPC_CMD_RESET);
        axw(`FPC_OFF_PROT, 8'h0f);
        unlock(`FPC_CMD_PAGE);
        `CHK("no walk", 1'b0, cpu_idle)
        pr(1'b0, 13'h1e00, 8'h00, 1'b0);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        opt(8'h3e);
        `CHK("trim reset", 8'h00, trim_data_reg)
        axw(`FPC_OFF_CTRL, `FPC_CMD_PROT);
        axr(`FPC_OFF_PROT);
        `CHK("protect reset", 8'h00, rd)
        stop_test;
    end
endmodule // tb

//--- verilog/fpc_ctrl.v
// flash protect and byte program controller with an axi4-lite slave
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "fpc_regs.vh"
module fpc_ctrl #(
    parameter ADDR_W    = 13,
    parameter PAGE_BITS = 9,
    parameter SECTORS   = 8
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire [13:0]       s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [13:0]       s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire              dbg_prog_req,
    input  wire              cpu_prog_req,
    input  wire [ADDR_W-1:0] prog_addr,
    input  wire [7:0]        prog_data,
    output reg               prog_done,
    output reg               prog_refused,
    output wire              cpu_idle,
    input  wire [ADDR_W-1:0] mem_raddr,
    output reg  [7:0]        mem_rdata,
    output reg               wdog_reset_select,
    output reg               wdog_always_on,
    output reg  [1:0]        clock_source_select,
    output reg               brownout_always_on,
    output reg               read_protect_opt,
    output reg               write_protect_opt,
    output reg  [7:0]        trim_data_reg
);
    localparam DEPTH = 1 << ADDR_W;
    localparam SEC_SH = ADDR_W - 3;
    // lock states, one-hot
    localparam ST_LOCKED = 5'b00001;
    localparam ST_UNLK1  = 5'b00010;
    localparam ST_UNLKD  = 5'b00100;
    localparam ST_MASS   = 5'b01000;
    localparam ST_PAGE   = 5'b10000;

    // program memory; never reset, it keeps its contents
    reg  [7:0]        mem [0:DEPTH-1];
    reg  [4:0]        state;
    reg  [7:0]        ctrl_reg;
    reg               prot_mapped;
    reg  [7:0]        sector_protection;
    reg  [7:0]        page_sel;
    reg  [ADDR_W-1:0] sw_addr;
    reg  [7:0]        sw_data;
    reg  [3:0]        busy_cnt;
    reg               busy;
    reg  [ADDR_W-1:0] busy_addr;
    reg  [7:0]        busy_data;
    reg               sw_prog;
    reg               opt_load;
    reg               aw_held;
    reg               w_held;
    reg  [11:0]       aw_addr;
    reg  [7:0]        w_byte;
    reg               w_lane0;
    reg  [ADDR_W-1:0] erase_ptr;
    reg               erasing;
    // last address of the walk, fixed at start so page select cannot move it
    reg  [ADDR_W-1:0] erase_end;
    reg  [ADDR_W-1:0] req_addr;
    reg  [7:0]        req_data;
    reg               req;

    // sector index of an address: top three address bits
    function [2:0] sector_of;
        input [ADDR_W-1:0] a;
        begin
            sector_of = a[ADDR_W-1:SEC_SH];
        end
    endfunction

    // program window decision for byte program; erase commands test sector protection themselves
    function allowed;
        input [ADDR_W-1:0] a;
        input [4:0]        st;
        input [7:0]        prot;
        input [7:0]        pg;
        begin
            allowed = 1'b0;
            if (!prot[sector_of(a)]) begin
                if (st == ST_MASS)
                    allowed = 1'b1;
                else if (st == ST_PAGE)
                    allowed = (a[ADDR_W-1:PAGE_BITS] ==
                               pg[ADDR_W-PAGE_BITS-1:0]);
            end
        end
    endfunction

    // a write lands once both halves are held and the last answer is taken
    wire wr_fire = aw_held && w_held && !s_axi_bvalid;
    wire aw_take = s_axi_awvalid && !aw_held;
    wire w_take  = s_axi_wvalid && !w_held;
    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    assign cpu_idle      = busy || erasing;
    // a level request still stands in the cycle that shows its answer
    wire pin_req = (dbg_prog_req || cpu_prog_req) &&
                   !prog_done && !prog_refused;
    // a software program waits until the engine is free
    wire sw_take = sw_prog && !busy && !erasing;

    // commands only count when byte lane zero is enabled
    wire ctrl_wr = wr_fire && w_lane0 && aw_addr == `FPC_OFF_CTRL;
    // first address of the selected page
    wire [ADDR_W-1:0] pg_top = {page_sel[ADDR_W-PAGE_BITS-1:0],
                                {PAGE_BITS{1'b0}}};

    // software program has priority over the pins
    always @* begin
        req = 1'b0;
        req_addr = prog_addr;
        req_data = prog_data;
        if (sw_prog) begin
            req = 1'b1;
            req_addr = sw_addr;
            req_data = sw_data;
        end else if (pin_req) begin
            req = 1'b1;
        end
    end

    // write channel capture, either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 12'h000;
            w_byte  <= `FPC_ZERO8;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `FPC_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[13:2];
            end
            if (w_take) begin
                w_held  <= 1'b1;
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    `FPC_OFF_CTRL, `FPC_OFF_PROT, `FPC_OFF_TRIM,
                    `FPC_OFF_ADDR, `FPC_OFF_DATA, `FPC_OFF_OPT:
                        s_axi_bresp <= `FPC_RESP_OKAY;
                    default:
                        s_axi_bresp <= `FPC_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control register, command decode and lock state machine
    always @(posedge aclk) begin
        if (!aresetn) begin
            state       <= ST_LOCKED;
            ctrl_reg    <= `FPC_ZERO8;
            prot_mapped <= 1'b0;
            page_sel    <= `FPC_ZERO8;
            sector_protection <= `FPC_ZERO8;
            trim_data_reg <= `FPC_ZERO8;
            sw_addr     <= {ADDR_W{1'b0}};
            sw_data     <= `FPC_ZERO8;
            sw_prog     <= 1'b0;
            erasing     <= 1'b0;
            erase_end   <= {ADDR_W{1'b0}};
            erase_ptr   <= {ADDR_W{1'b0}};
        end else begin
            if (sw_take)
                sw_prog <= 1'b0;
            if (erasing) begin
                if (erase_ptr == erase_end)
                    erasing <= 1'b0;
                else
                    erase_ptr <= erase_ptr + 1'b1;
            end
            if (ctrl_wr) begin
                ctrl_reg    <= w_byte;
                prot_mapped <= (w_byte == `FPC_CMD_PROT);
                case (w_byte)
                    `FPC_CMD_RESET: state <= ST_LOCKED;
                    `FPC_CMD_UNLOCK1:
                        state <= (state == ST_LOCKED) ? ST_UNLK1 : ST_LOCKED;
                    `FPC_CMD_UNLOCK2:
                        state <= (state == ST_UNLK1) ? ST_UNLKD : ST_LOCKED;
                    `FPC_CMD_MASS: begin
                        if (state == ST_UNLKD && sector_protection ==
                            `FPC_ZERO8) begin
                            state      <= ST_MASS;
                            erasing    <= 1'b1;
                            erase_end  <= {ADDR_W{1'b1}};
                            erase_ptr  <= {ADDR_W{1'b0}};
                        end else begin
                            state <= ST_LOCKED;
                        end
                    end
                    `FPC_CMD_PAGE: begin
                        if (state == ST_UNLKD &&
                            !sector_protection[sector_of(pg_top)]) begin
                            state      <= ST_PAGE;
                            erasing    <= 1'b1;
                            erase_end  <= pg_top | {{(ADDR_W-PAGE_BITS){1'b0}},
                                                    {PAGE_BITS{1'b1}}};
                            erase_ptr  <= pg_top;
                        end else begin
                            state <= ST_LOCKED;
                        end
                    end
                    default: state <= ST_LOCKED;
                endcase
            end
            if (wr_fire && w_lane0) begin
                case (aw_addr)
                    `FPC_OFF_PROT: begin
                        if (prot_mapped)
                            sector_protection <= sector_protection |
                                                 w_byte;
                        else
                            page_sel <= w_byte;
                    end
                    `FPC_OFF_TRIM: trim_data_reg <= w_byte;
                    // address bytes shift in, high byte first
                    `FPC_OFF_ADDR: sw_addr <= {sw_addr[ADDR_W-9:0], w_byte};
                    `FPC_OFF_DATA: begin
                        sw_data <= w_byte;
                        sw_prog <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // byte program engine and option load strobe, also raised when the erase walk reaches byte 0
    always @(posedge aclk) begin
        if (!aresetn) begin
            busy         <= 1'b0;
            busy_cnt     <= 4'h0;
            busy_addr    <= {ADDR_W{1'b0}};
            busy_data    <= `FPC_ZERO8;
            prog_done    <= 1'b0;
            prog_refused <= 1'b0;
            opt_load     <= 1'b1;
        end else begin
            prog_done    <= 1'b0;
            prog_refused <= 1'b0;
            opt_load     <= 1'b0;
            if (busy) begin
                if (busy_cnt == `FPC_PROG_CYCLES) begin
                    busy <= 1'b0;
                    prog_done <= 1'b1;
                    opt_load  <= (busy_addr == `FPC_OPT_ADDR);
                end
                busy_cnt <= busy_cnt + 4'h1;
            end else if (req && !erasing) begin
                if (allowed(req_addr, state, sector_protection,
                            page_sel)) begin
                    busy      <= 1'b1;
                    busy_cnt  <= 4'h1;
                    busy_addr <= req_addr;
                    busy_data <= req_data;
                end else begin
                    prog_refused <= 1'b1;
                end
            end
            if (erasing && erase_ptr == `FPC_OPT_ADDR)
                opt_load <= 1'b1;
        end
    end

    // flash array: erase sets ones, program only clears
    always @(posedge aclk) begin
        if (erasing)
            mem[erase_ptr] <= `FPC_ERASED;
        else if (busy && busy_cnt == `FPC_PROG_CYCLES)
            mem[busy_addr] <= mem[busy_addr] & busy_data;
    end

    // option bits decoded from byte 0, untouched by reset
    always @(posedge aclk) begin
        if (opt_load) begin
            wdog_reset_select   <= mem[`FPC_OPT_ADDR][`FPC_OPT_WD_RES];
            wdog_always_on      <= mem[`FPC_OPT_ADDR][`FPC_OPT_WD_AO];
            clock_source_select <= mem[`FPC_OPT_ADDR][`FPC_OPT_OSC_HI:
                                                      `FPC_OPT_OSC_LO];
            brownout_always_on  <= mem[`FPC_OPT_ADDR][`FPC_OPT_BO_AO];
            read_protect_opt    <= mem[`FPC_OPT_ADDR][`FPC_OPT_RD_PROT];
            write_protect_opt   <= mem[`FPC_OPT_ADDR][`FPC_OPT_WR_PROT];
        end
    end

    always @(posedge aclk) begin
        mem_rdata <= mem[mem_raddr];
    end

    // read channel, one cycle answer
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `FPC_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `FPC_RESP_OKAY;
            case (s_axi_araddr[13:2])
                `FPC_OFF_CTRL: s_axi_rdata <= {24'h000000, ctrl_reg};
                `FPC_OFF_PROT: s_axi_rdata <= {24'h000000,
                    prot_mapped ? sector_protection : page_sel};
                `FPC_OFF_TRIM: s_axi_rdata <= {24'h000000, trim_data_reg};
                // status: erasing, busy, spare zeros, one-hot lock state
                `FPC_OFF_STAT: s_axi_rdata <= {22'h0, erasing, busy,
                    3'b000, state};
                `FPC_OFF_OPT:  s_axi_rdata <= {24'h000000,
                    mem[`FPC_OPT_ADDR]};
                `FPC_OFF_ADDR: s_axi_rdata <= {24'h000000, sw_addr[7:0]};
                `FPC_OFF_DATA: s_axi_rdata <= {24'h000000, sw_data};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `FPC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // fpc_ctrl

//--- verilog/fpc_regs.vh
// register offsets, command codes and field positions of the flash controller
`ifndef FPC_REGS_VH
`define FPC_REGS_VH
`define FPC_OFF_CTRL      12'hff8
`define FPC_OFF_PROT      12'hff9
`define FPC_OFF_TRIM      12'hff7
`define FPC_OFF_PAGE      12'hffa
`define FPC_OFF_ADDR      12'hffb
`define FPC_OFF_DATA      12'hffc
`define FPC_OFF_STAT      12'hffd
`define FPC_OFF_OPT       12'hffe
`define FPC_CMD_RESET     8'h00
`define FPC_CMD_PROT      8'h5e
`define FPC_CMD_UNLOCK1   8'h73
`define FPC_CMD_UNLOCK2   8'h8c
`define FPC_CMD_MASS      8'h63
`define FPC_CMD_PAGE      8'h95
`define FPC_ERASED        8'hff
`define FPC_ZERO8         8'h00
`define FPC_OPT_ADDR      13'h0000
`define FPC_OPT_WD_RES    7
`define FPC_OPT_WD_AO     6
`define FPC_OPT_OSC_HI    5
`define FPC_OPT_OSC_LO    4
`define FPC_OPT_BO_AO     3
`define FPC_OPT_RD_PROT   2
`define FPC_OPT_WR_PROT   0
`define FPC_RESP_OKAY     2'b00
`define FPC_RESP_SLVERR   2'b10
`define FPC_PROG_CYCLES   4'h8
`endif
